// file: include/spo_regs.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 100 MHz clock, byte addresses on the register bus
// Notes: definitions only
`ifndef SPO_REGS_SVH
`define SPO_REGS_SVH

`define CLK_MHZ 100
`define MS_PERIOD_US 1000
`define MS_CYCLES (`CLK_MHZ * `MS_PERIOD_US)
`define MONO_FAST_US 20
`define MONO_SLOW_US 30
`define MONO_FAST_CYC (`CLK_MHZ * `MONO_FAST_US)
`define MONO_SLOW_CYC (`CLK_MHZ * `MONO_SLOW_US)

`define REG_CTRL 5'h00
`define REG_OFFSET 5'h04
`define REG_CHAN_A 5'h08
`define REG_CHAN_B 5'h0C
`define REG_STATUS 5'h10
`define REG_POS_A 5'h14
`define REG_POS_B 5'h18

`define CTRL_DEPTH_LSB 0
`define CTRL_DIR_NEG 5
`define CTRL_ENC_LSB 6
`define CTRL_REACT_LSB 8
`define CTRL_RANGE_EDGE 11
`define CTRL_SERVICE 12
`define CTRL_RESET 32'h0000_0848

`define CHAN_RES_LSB 0
`define CHAN_WIDTH_LSB 3
`define CHAN_ERRBIT 6
`define CHAN_FAST 7
`define CHAN_RESET 8'hDB

`define DEPTH_MIN 5'h02
`define DEPTH_MAX 5'h10
`define ENC_SWAP 2'h2
`define OFFSET_MAX_MM 32'sd10000000
`define WIDTH_BASE 6'd21
`define FRAME_BITS 28

`define REACT_MS_0 9'd10
`define REACT_MS_1 9'd20
`define REACT_MS_2 9'd50
`define REACT_MS_3 9'd100
`define REACT_MS_4 9'd200
`define REACT_MS_5 9'd400

`endif

// file: include/spo_pkg.sv
// Purpose: shared types of the position output path
// Assumes: nothing
// Notes: one-hot pipeline states
package spo_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_READ = 5'b00010,
        ST_ACCUM = 5'b00100,
        ST_MEAN = 5'b01000,
        ST_OUT = 5'b10000
    } pipe_state_e;
    typedef logic signed [39:0] wide_pos_t;
endpackage

// file: rtl/sample_memory.sv
// Purpose: sample store for the sliding window
// Assumes: one write and one read per cycle
// Notes: read data registered, no reset on the array
module sample_memory #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// file: rtl/safe_position_output_processing.sv
// Purpose: averages raw positions, applies direction and offset, checks range,
//          and shifts the result out on two synchronous-serial channels
// Assumes: raw_pos in 0.01 mm on the local clock; channel clocks and fault pins asynchronous
// Notes: registers on Avalon-MM, one wait state per access
// Function
// - position is sliding mean, depth configurable, least 2, default 8
// - memory is a FIFO: each ms one new sample in, oldest out
// - each ms mean recomputed and offered to both channels
// - positive direction, the default, passes the position unchanged
// - negative direction negates position before offset is added
// - offset in mm, range plus or minus ten million, default zero
// - final position zero or negative raises external error
// - position beyond 24 to 27 bit data width flags overflow, external error
// - same value on both channels, binary on one, Gray on other
// - setting 1 gives Gray on A, setting 2 Gray on B
// - external error delayed by reaction time, shorter conditions ignored
// - reaction time 10, 20, 50, 100, 200 or 400 ms, default 10
// - internal errors signalled at once, no delay
// - range switch at label edge when 1, the default, centre when 0
// - service mode forces external error on both channels
// - leaving service mode clears the forced external error
// - position data only offered after error-free startup
// - general settings are single values shared by both channels
// - resolution per channel: 2 is 0.01, 3 is 0.1 (default), 4 is 1 mm
// - width per channel: codes 3 to 6 give 24 to 27 bits, 3 default
// - optional error bit appended to frame, set on external error
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`include "spo_regs.svh"
module safe_position_output_processing #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] raw_pos,
    input wire logic raw_ok,
    input wire logic ext_fault_pin,
    input wire logic int_fault_pin,
    input wire logic first_position_channel_clock,
    input wire logic second_position_channel_clock,
    output logic first_position_channel_data,
    output logic second_position_channel_data,
    output logic external_error,
    output logic internal_error,
    output logic range_switch_label_edge,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    logic [31:0] ctrl_r;
    logic [31:0] offset_r;
    logic [7:0] chan_r [2];
    logic ack_r;
    logic cfg_wr;
    logic [4:0] depth;
    logic dir_neg;
    logic enc_swap;
    logic service;
    logic [8:0] react_ms;
    logic [16:0] ms_cnt_r;
    logic ms_tick;
    spo_pkg::pipe_state_e st_r;
    logic [31:0] sample_r;
    logic sample_ok_r;
    logic [3:0] wr_ptr_r;
    logic [3:0] rd_addr;
    logic [31:0] old_data;
    logic [4:0] fill_r;
    logic signed [35:0] sum_r;
    logic signed [35:0] mean_r;
    spo_pkg::wide_pos_t final_r [2];
    spo_pkg::wide_pos_t off_scaled [2];
    spo_pkg::wide_pos_t scaled [2];
    logic [26:0] word_r [2];
    logic [1:0] nonpos;
    logic [1:0] ovf;
    logic ready_r;
    logic [1:0] ext_sy_r;
    logic [1:0] int_sy_r;
    logic ext_cond;
    logic [8:0] react_cnt_r;
    logic ext_dly_r;
    logic [1:0] chan_data;

    assign depth = ctrl_r[`CTRL_DEPTH_LSB +: 5];
    assign dir_neg = ctrl_r[`CTRL_DIR_NEG];
    assign enc_swap = (ctrl_r[`CTRL_ENC_LSB +: 2] == `ENC_SWAP);
    assign service = ctrl_r[`CTRL_SERVICE];
    assign range_switch_label_edge = ctrl_r[`CTRL_RANGE_EDGE];
    assign cfg_wr = write && ack_r && (address == `REG_CTRL || address == `REG_OFFSET
                    || address == `REG_CHAN_A || address == `REG_CHAN_B);

    // bus: every access answered on the second edge
    assign waitrequest = ~ack_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read || write) && !ack_r;
        end
    end

    // one common set of general settings, writes to depth, encoding and offset clamped to legal values
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= `CTRL_RESET;
            offset_r <= 32'h0000_0000;
            chan_r[0] <= `CHAN_RESET;
            chan_r[1] <= `CHAN_RESET;
        end else if (write && ack_r) begin
            unique case (address)
                `REG_CTRL: begin
                    ctrl_r <= {19'h0, writedata[12:8],
                        (writedata[7:6] == `ENC_SWAP) ? 2'h2 : 2'h1, writedata[5],
                        (writedata[4:0] < `DEPTH_MIN) ? `DEPTH_MIN :
                        (writedata[4:0] > `DEPTH_MAX) ? `DEPTH_MAX : writedata[4:0]};
                end
                `REG_OFFSET: begin
                    offset_r <= ($signed(writedata) > `OFFSET_MAX_MM) ? `OFFSET_MAX_MM :
                        ($signed(writedata) < -`OFFSET_MAX_MM) ? -`OFFSET_MAX_MM : writedata;
                end
                `REG_CHAN_A: chan_r[0] <= writedata[7:0];
                `REG_CHAN_B: chan_r[1] <= writedata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack_r) begin
            unique case (address)
                `REG_CTRL: readdata <= ctrl_r;
                `REG_OFFSET: readdata <= offset_r;
                `REG_CHAN_A: readdata <= {24'h0, chan_r[0]};
                `REG_CHAN_B: readdata <= {24'h0, chan_r[1]};
                `REG_STATUS: readdata <= {25'h0, ext_cond, ovf, |nonpos, ready_r,
                                          internal_error, external_error};
                `REG_POS_A: readdata <= {5'h0, word_r[0]};
                `REG_POS_B: readdata <= {5'h0, word_r[1]};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    // millisecond enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ms_cnt_r <= 17'h0;
        end else if (ms_cnt_r == 17'(MS_CYCLES - 1)) begin
            ms_cnt_r <= 17'h0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 17'h1;
        end
    end
    assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));

    // oldest slot: a full window of 16 wraps onto the slot about to be overwritten
    assign rd_addr = wr_ptr_r - depth[3:0];

    sample_memory #(.WIDTH(32), .DEPTH(16), .AW(4)) u_mem (
        .clock(clock),
        .wr_en(st_r == spo_pkg::ST_ACCUM),
        .wr_addr(wr_ptr_r),
        .wr_data(sample_r),
        .rd_addr(rd_addr),
        .rd_data(old_data)
    );

    // averaging pipeline, one pass per ms; a settings write restarts startup
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= spo_pkg::ST_IDLE;
            sample_r <= 32'h0;
            sample_ok_r <= 1'b0;
            wr_ptr_r <= 4'h0;
            fill_r <= 5'h0;
            sum_r <= 36'sh0;
            mean_r <= 36'sh0;
            ready_r <= 1'b0;
        end else if (cfg_wr) begin
            st_r <= spo_pkg::ST_IDLE;
            wr_ptr_r <= 4'h0;
            fill_r <= 5'h0;
            sum_r <= 36'sh0;
            ready_r <= 1'b0;
        end else begin
            unique case (st_r)
                spo_pkg::ST_IDLE: begin
                    if (ms_tick) begin
                        sample_r <= raw_pos;
                        sample_ok_r <= raw_ok;
                        st_r <= spo_pkg::ST_READ;
                    end
                end
                spo_pkg::ST_READ: st_r <= spo_pkg::ST_ACCUM;
                spo_pkg::ST_ACCUM: begin
                    sum_r <= sum_r + 36'($signed(sample_r))
                             - ((fill_r == depth) ? 36'($signed(old_data)) : 36'sh0);
                    if (fill_r != depth) begin
                        fill_r <= fill_r + 5'h1;
                    end
                    wr_ptr_r <= wr_ptr_r + 4'h1;
                    st_r <= spo_pkg::ST_MEAN;
                end
                spo_pkg::ST_MEAN: begin
                    mean_r <= sum_r / $signed({31'h0, fill_r});
                    st_r <= spo_pkg::ST_OUT;
                end
                spo_pkg::ST_OUT: begin
                    ready_r <= (fill_r == depth) && !int_sy_r[1] ? 1'b1 : ready_r && !int_sy_r[1];
                    st_r <= spo_pkg::ST_IDLE;
                end
            endcase
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        logic [2:0] res;
        logic [5:0] width;
        logic is_gray;
        logic [2:0] sclk_sy_r;
        logic busy_r;
        logic done_r;
        logic [4:0] bits_r;
        logic [27:0] sh_r;
        logic [11:0] mono_r;
        logic data_r;
        logic [27:0] frame;
        logic [4:0] nbits;
        logic [26:0] bin;
        logic err_bit;

        assign res = chan_r[g][`CHAN_RES_LSB +: 3];
        assign width = `WIDTH_BASE + {3'h0, chan_r[g][`CHAN_WIDTH_LSB +: 3]};
        assign is_gray = (g == 0) ? !enc_swap : enc_swap;
        assign bin = final_r[g][26:0];

        // resolution scaling truncates toward zero before the checks
        always_comb begin
            unique case (res)
                3'h2: begin
                    scaled[g] = 40'(mean_r);
                    off_scaled[g] = 40'($signed(offset_r)) * 40'sd100;
                end
                3'h4: begin
                    scaled[g] = 40'(mean_r / 36'sd100);
                    off_scaled[g] = 40'($signed(offset_r));
                end
                default: begin
                    scaled[g] = 40'(mean_r / 36'sd10);
                    off_scaled[g] = 40'($signed(offset_r)) * 40'sd10;
                end
            endcase
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                final_r[g] <= 40'sh0;
                word_r[g] <= 27'h0;
            end else if (st_r == spo_pkg::ST_OUT) begin
                final_r[g] <= off_scaled[g] + (dir_neg ? -scaled[g] : scaled[g]);
            end else if (st_r == spo_pkg::ST_IDLE) begin
                word_r[g] <= !ready_r ? 27'h0 :
                    is_gray ? (bin ^ (bin >> 1)) : bin;
            end
        end

        assign nonpos[g] = (final_r[g] <= 40'sh0);
        assign ovf[g] = (final_r[g] >= (40'sh1 <<< width));

        // a falling clock-line edge after the frame drives data low until the monoflop expires; idle line is high
        assign err_bit = external_error || !ready_r;
        assign frame = {word_r[g], err_bit} << (6'd27 - width);
        assign nbits = width[4:0] + {4'h0, chan_r[g][`CHAN_ERRBIT]};

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                sclk_sy_r <= 3'b111;
            end else begin
                sclk_sy_r <= {sclk_sy_r[1:0], (g == 0) ? first_position_channel_clock
                                                      : second_position_channel_clock};
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                busy_r <= 1'b0;
                done_r <= 1'b0;
                bits_r <= 5'h0;
                sh_r <= 28'h0;
                mono_r <= 12'h0;
                data_r <= 1'b1;
            end else if (sclk_sy_r[1] != sclk_sy_r[2]) begin
                mono_r <= chan_r[g][`CHAN_FAST] ? 12'(`MONO_FAST_CYC) : 12'(`MONO_SLOW_CYC);
                if (!sclk_sy_r[1] && !busy_r && !done_r) begin
                    sh_r <= frame;
                    bits_r <= nbits;
                    busy_r <= 1'b1;
                end else if (sclk_sy_r[1] && busy_r) begin
                    data_r <= sh_r[27];
                    sh_r <= sh_r << 1;
                    bits_r <= bits_r - 5'h1;
                    if (bits_r == 5'h1) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end
                end else if (!sclk_sy_r[1] && done_r) begin
                    data_r <= 1'b0;
                end
            end else if (mono_r != 12'h0) begin
                mono_r <= mono_r - 12'h1;
                if (mono_r == 12'h1) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b0;
                    data_r <= 1'b1;
                end
            end
        end
        assign chan_data[g] = data_r;
    end
    assign first_position_channel_data = chan_data[0];
    assign second_position_channel_data = chan_data[1];

    // fault pins: two-stage synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_sy_r <= 2'b00;
            int_sy_r <= 2'b00;
        end else begin
            ext_sy_r <= {ext_sy_r[0], ext_fault_pin};
            int_sy_r <= {int_sy_r[0], int_fault_pin};
        end
    end

    // service mode is not delayed: it is an operator action, not a transient
    assign ext_cond = ext_sy_r[1] || (ready_r && (!sample_ok_r || |nonpos || |ovf));

    always_comb begin
        unique case (ctrl_r[`CTRL_REACT_LSB +: 3])
            3'h1: react_ms = `REACT_MS_1;
            3'h2: react_ms = `REACT_MS_2;
            3'h3: react_ms = `REACT_MS_3;
            3'h4: react_ms = `REACT_MS_4;
            3'h5: react_ms = `REACT_MS_5;
            default: react_ms = `REACT_MS_0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            react_cnt_r <= 9'h0;
            ext_dly_r <= 1'b0;
        end else if (!ext_cond) begin
            react_cnt_r <= 9'h0;
            ext_dly_r <= 1'b0;
        end else if (ms_tick && !ext_dly_r) begin
            react_cnt_r <= react_cnt_r + 9'h1;
            ext_dly_r <= (react_cnt_r + 9'h1 >= react_ms);
        end
    end

    assign external_error = ext_dly_r || service;
    assign internal_error = int_sy_r[1];

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_pass;
        st_r == spo_pkg::ST_READ ##1 st_r == spo_pkg::ST_ACCUM
        ##1 st_r == spo_pkg::ST_MEAN ##1 st_r == spo_pkg::ST_OUT;
    endsequence

    a_depth_legal: assert property (depth >= `DEPTH_MIN && depth <= `DEPTH_MAX)
        else $error("window depth outside 2..16");
    // a settings write restarts the pass, so such cycles are not judged
    a_pass_per_ms: assert property (disable iff (rst || cfg_wr)
        ms_tick && st_r == spo_pkg::ST_IDLE |=> s_pass)
        else $error("averaging pass did not follow the ms tick");
    a_word_update: assert property (disable iff (rst || cfg_wr)
        st_r == spo_pkg::ST_OUT ##1 ready_r |=>
        word_r[0] == (!enc_swap ? (final_r[0][26:0] ^ (final_r[0][26:0] >> 1)) : final_r[0][26:0]))
        else $error("channel A word not refreshed after the pass");
    a_dir_sign: assert property (st_r == spo_pkg::ST_OUT && chan_r[0][2:0] == 3'h2
        && !cfg_wr |=> final_r[0] == 40'($signed(offset_r)) * 40'sd100
        + (dir_neg ? -40'($past(mean_r)) : 40'($past(mean_r))))
        else $error("direction sign wrong on channel A");
    a_nonpos_err: assert property (ready_r && final_r[0] <= 40'sh0 |-> ext_cond)
        else $error("non-positive position not pending as error");
    a_overflow_err: assert property (ready_r && |ovf |-> ext_cond)
        else $error("overflow not pending as error");
    a_gray_pair: assert property (ready_r && chan_r[0] == chan_r[1] && !enc_swap |->
        word_r[0] == (word_r[1] ^ (word_r[1] >> 1)))
        else $error("channel A is not the Gray image of channel B");
    a_react_hold: assert property ($rose(ext_cond) |-> !ext_dly_r [*8])
        else $error("external error raised before the reaction time");
    a_react_clear: assert property (!ext_cond |=> !ext_dly_r)
        else $error("delayed error survived a cleared condition");
    a_int_direct: assert property (int_sy_r[1] |-> internal_error)
        else $error("internal error delayed");
    a_service_err: assert property (service |-> external_error)
        else $error("service mode without external error");
    a_service_leave: assert property ($fell(service) && !ext_dly_r |-> !external_error)
        else $error("external error kept after leaving service mode");
    a_ready_gate: assert property (!ready_r ##1 !ready_r |-> word_r[0] == 27'h0)
        else $error("position offered before startup finished");
endmodule

// file: tb/ssi_master.sv
// Purpose: serial clock master that reads one position channel
// Assumes: 80 ns clock period, clock idles high between frames
// Notes: sampling on the falling edge gives the slave half a period to settle
module ssi_master (
    output logic ssi_clock,
    input wire logic ssi_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial ssi_clock = 1'b1;
    task automatic grab(input int nbits, output logic [31:0] word);
        word = 32'h0;
        // small offset keeps link edges off the system clock edges
        #3 ssi_clock = 1'b0;
        repeat (nbits) begin
            #40 ssi_clock = 1'b1;
            #40 ssi_clock = 1'b0;
            word = {word[30:0], ssi_data};
        end
        #40 ssi_clock = 1'b1;
        // stay idle past the fast monoflop so the next frame starts clean
        #30000;
    endtask
endmodule

// file: tb/safe_position_output_processing_tb.sv
// Purpose: self-checking bench for the position output path
// Assumes: MS_CYCLES cut to 100, so one ms is 100 clocks
// Notes: frames read by two serial master models in parallel
`include "spo_regs.svh"
module safe_position_output_processing_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [31:0] raw_pos = 32'h0001_E240;
    logic raw_ok = 1'b1;
    logic ext_fault_pin = 1'b0;
    logic int_fault_pin = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic a_clk, b_clk, a_dat, b_dat, external_error, internal_error, label_edge;
    logic [31:0] readdata, q;
    logic waitrequest;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    safe_position_output_processing #(.MS_CYCLES(100)) dut_u (
        .clock(clock), .rst(rst), .raw_pos(raw_pos), .raw_ok(raw_ok),
        .ext_fault_pin(ext_fault_pin), .int_fault_pin(int_fault_pin),
        .first_position_channel_clock(a_clk), .second_position_channel_clock(b_clk),
        .first_position_channel_data(a_dat), .second_position_channel_data(b_dat),
        .external_error(external_error), .internal_error(internal_error),
        .range_switch_label_edge(label_edge), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest)
    );
    ssi_master ma_u (.ssi_clock(a_clk), .ssi_data(a_dat));
    ssi_master mb_u (.ssi_clock(b_clk), .ssi_data(b_dat));

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // waitrequest and readdata are taken at the rising edge, before that edge's updates land
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    endtask

    task automatic ms(input int k);
        repeat (k * 100) @(posedge clock);
    endtask

    function automatic logic [31:0] frm(input logic g, input logic [23:0] p, input logic e);
        return {7'h00, g ? (p ^ (p >> 1)) : p, e};
    endfunction

    task automatic frames(input logic [31:0] ea, input logic [31:0] eb);
        logic [31:0] wa, wb;
        fork
            ma_u.grab(25, wa);
            mb_u.grab(25, wb);
        join
        chk("channel A frame", ea, wa);
        chk("channel B frame", eb, wb);
        chk("channel A idle", 32'h1, {31'h0, a_dat});
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        frames(frm(1, 24'h0, 1), frm(0, 24'h0, 1));
        bus(0, `REG_CTRL, 0); chk("ctrl reset", 32'h0000_0848, q);
        bus(0, `REG_OFFSET, 0); chk("offset reset", 32'h0, q);
        bus(0, `REG_CHAN_A, 0); chk("chan A reset", 32'h0000_00DB, q);
        bus(0, 5'h1C, 0); chk("unmapped read", 32'h0, q);
        chk("label edge", 32'h1, {31'h0, label_edge});
        ms(12);
        frames(frm(1, 24'd12345, 0), frm(0, 24'd12345, 0));
        bus(1, `REG_CTRL, 32'h0000_0888);
        ms(12);
        frames(frm(0, 24'd12345, 0), frm(1, 24'd12345, 0));
        $display("test defaults and encoding done");
        bus(1, `REG_OFFSET, 32'h0098_9681);
        bus(0, `REG_OFFSET, 0); chk("offset clamp", 32'h0098_9680, q);
        bus(1, `REG_OFFSET, 32'd2000);
        bus(1, `REG_CTRL, 32'h0000_0868);
        ms(12);
        frames(frm(1, 24'd7655, 0), frm(0, 24'd7655, 0));
        bus(1, `REG_OFFSET, 32'h0);
        ms(5); chk("early error", 32'h0, {31'h0, external_error});
        ms(20); chk("nonpositive error", 32'h1, {31'h0, external_error});
        bus(0, `REG_STATUS, 0); chk("nonpositive flag", 32'h1, {31'h0, q[3]});
        bus(1, `REG_OFFSET, 32'd2000);
        ms(12); chk("error cleared", 32'h0, {31'h0, external_error});
        $display("test direction and offset done");
        ext_fault_pin <= 1'b1;
        ms(5);
        ext_fault_pin <= 1'b0;
        ms(8); chk("short fault", 32'h0, {31'h0, external_error});
        bus(1, `REG_CTRL, 32'h0000_0968);
        ms(12);
        ext_fault_pin <= 1'b1;
        ms(15); chk("slow reaction", 32'h0, {31'h0, external_error});
        ms(10); chk("reaction done", 32'h1, {31'h0, external_error});
        ext_fault_pin <= 1'b0;
        int_fault_pin <= 1'b1;
        repeat (4) @(posedge clock);
        chk("internal error", 32'h1, {31'h0, internal_error});
        int_fault_pin <= 1'b0;
        $display("test reaction times done");
        bus(1, `REG_CTRL, 32'h0000_1968);
        @(posedge clock);
        chk("service error", 32'h1, {31'h0, external_error});
        ms(12);
        frames(frm(1, 24'd7655, 1), frm(0, 24'd7655, 1));
        bus(1, `REG_CTRL, 32'h0000_0968);
        repeat (3) @(posedge clock);
        chk("service left", 32'h0, {31'h0, external_error});
        $display("test service mode done");
        bus(1, `REG_CTRL, 32'h0000_0948);
        bus(1, `REG_CHAN_A, 32'h0000_00DA);
        raw_pos <= 32'h0131_2D00;
        ms(30); chk("overflow error", 32'h1, {31'h0, external_error});
        bus(0, `REG_STATUS, 0); chk("overflow flags", 32'h1, {30'h0, q[5:4]});
        $display("test overflow done");
        wrap_up();
    end
endmodule
